//--- common/rst_seq_pkg.sv
// Constants, field layouts and carriers shared by the reset sequencer files
package rst_seq_pkg;

    // Reference clock period; every sequencing count below is in reference cycles
    localparam int CLK_PERIOD_NS = 40;

    // Sequencing counts in reference-clock cycles
    localparam int PIN_LOW_CYC = 32;
    localparam int HOLD_CYC = 32;
    localparam int STAB_CYC = 4096;
    localparam int CNT_W = 13;

    // Least low time on the reset pin, rounded up to whole cycles
    localparam int MIN_LOW_NS = 100;
    localparam int MIN_LOW_CYC = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOWC_W = 4;

    // Vector and watchdog-clear locations
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
    localparam logic [15:0] WDOG_CLR_ADDR = 16'hFFFF;

    // Liveness watchdog counter width
    localparam int WDOG_W = 18;

    // Bus clock source select and divider
    localparam logic BUSCLK_DIV4 = 1'b0;
    localparam logic [1:0] BUS_DIV_LAST = 2'h3;

    // Reset cause layout, bit 7 first
    typedef struct packed {
        logic power_on_flag;
        logic ext_pin_flag;
        logic wdog_flag;
        logic bad_opcode_flag;
        logic bad_fetch_flag;
        logic monitor_entry_flag;
        logic low_supply_flag;
        logic zero_bit;
    } cause_s;

    // Power-on sets the power-on and low-supply flags only
    localparam logic [7:0] CAUSE_RST_VAL = 8'h82;

    // One CPU bus access as seen by the sequencer
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic fetch;
    } cpu_access_s;

endpackage : rst_seq_pkg

//--- src/level_sync3.sv
// Three-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module level_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level
);

    logic ff1_q;
    logic ff2_q;
    logic ff3_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ff1_q <= RST_VAL;
            ff2_q <= RST_VAL;
            ff3_q <= RST_VAL;
        end else begin
            ff1_q <= i_async;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    // Change accepted only once two settled stages agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_level <= RST_VAL;
        end else if (ff2_q == ff3_q) begin
            o_level <= ff3_q;
        end
    end

endmodule : level_sync3

//--- src/liveness_watchdog.sv
// Liveness watchdog counter with clear-on-write and overflow pulse
`timescale 1ns/1ps
module liveness_watchdog import rst_seq_pkg::*; #(
    parameter int LIMIT = 32'h0003_FFF0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_clear,
    output logic o_ovf
);

    localparam logic [WDOG_W-1:0] LAST = WDOG_W'(LIMIT - 1);

    logic [WDOG_W-1:0] cnt_q;

    // Held at zero while the CPU is in reset, so each run starts a full period
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_run || i_clear) begin
            cnt_q <= '0;
            o_ovf <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
            o_ovf <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            o_ovf <= 1'b0;
        end
    end

endmodule : liveness_watchdog

//--- src/mcu_reset_sequencer.sv
// Reset source gathering, reset pin drive, stabilization and vector fetch sequencing
`timescale 1ns/1ps
module mcu_reset_sequencer import rst_seq_pkg::*; #(
    parameter int WDOG_LIMIT = 32'h0003_FFF0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_on,
    input wire logic i_supply_low,
    input wire logic i_rst_pin,
    output logic o_rst_pin_o,
    output logic o_rst_pin_oe,
    input wire cpu_access_s i_cpu,
    input wire logic i_unmapped,
    input wire logic i_opcode_bad,
    input wire logic i_opcode_stop,
    input wire logic i_stop_allow,
    input wire logic i_monitor_entry,
    input wire logic [7:0] i_vec_data,
    output logic [15:0] o_vec_addr,
    output logic o_vec_rd,
    output logic [15:0] o_pc,
    output logic o_cpu_start,
    output logic o_cpu_rst,
    output logic o_clk_en,
    input wire logic i_pll_ce,
    input wire logic i_busclk_wr,
    input wire logic i_busclk_sel,
    output logic o_busclk_sel,
    output logic o_bus_ce,
    input wire logic i_cause_rd,
    output cause_s o_cause
);

    typedef enum logic [8:0] {
        S_RUN = 9'h001,
        S_STAB = 9'h002,
        S_SUPPLY_LOW = 9'h004,
        S_EXT_LOW = 9'h008,
        S_PIN_LOW = 9'h010,
        S_HOLD = 9'h020,
        S_FETCH_HI = 9'h040,
        S_FETCH_LO = 9'h080,
        S_LOAD = 9'h100
    } seq_state_e;

    localparam logic [LOWC_W-1:0] LOWC_LAST = LOWC_W'(MIN_LOW_CYC - 1);

    seq_state_e state_q;
    seq_state_e nxt;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] len_q;
    logic [LOWC_W-1:0] lowc_q;
    logic [1:0] div_q;
    logic pin_s;
    logic sup_s;
    logic wd_ovf;
    logic run;
    logic done;
    logic op_bad;
    logic fetch_bad;
    logic int_evt;
    logic ext_evt;
    logic hold_low;
    cause_s set_v;

    level_sync3 #(.RST_VAL(1'b1)) u_pin_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_rst_pin),
        .o_level(pin_s)
    );

    level_sync3 #(.RST_VAL(1'b0)) u_sup_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_supply_low),
        .o_level(sup_s)
    );

    liveness_watchdog #(.LIMIT(WDOG_LIMIT)) u_wdog (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(run),
        .i_clear(i_cpu.wr && i_cpu.addr == WDOG_CLR_ADDR),
        .o_ovf(wd_ovf)
    );

    assign run = (state_q == S_RUN);
    assign done = (cnt_q == '0);
    // Data reads never look at i_unmapped, only opcode fetches do
    assign op_bad = i_cpu.fetch && (i_opcode_bad || (i_opcode_stop && !i_stop_allow));
    assign fetch_bad = i_cpu.fetch && i_unmapped;
    assign int_evt = run && (wd_ovf || op_bad || fetch_bad || i_monitor_entry);
    assign ext_evt = run && !pin_s && (lowc_q == LOWC_LAST);
    assign hold_low = (state_q == S_HOLD) && done && !pin_s;

    // Power-on outranks low supply, which outranks everything else
    always_comb begin
        nxt = state_q;
        if (i_power_on) begin
            nxt = S_STAB;
        end else if (sup_s) begin
            nxt = S_SUPPLY_LOW;
        end else begin
            case (state_q)
                S_RUN: begin
                    if (int_evt) begin
                        nxt = S_PIN_LOW;
                    end else if (ext_evt) begin
                        nxt = S_EXT_LOW;
                    end
                end
                S_SUPPLY_LOW: nxt = S_STAB;
                S_STAB: begin
                    if (done) begin
                        nxt = S_PIN_LOW;
                    end
                end
                S_PIN_LOW: begin
                    if (done) begin
                        nxt = S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (done) begin
                        nxt = pin_s ? S_FETCH_HI : S_EXT_LOW;
                    end
                end
                S_EXT_LOW: begin
                    if (pin_s) begin
                        nxt = S_HOLD;
                    end
                end
                S_FETCH_HI: nxt = S_FETCH_LO;
                S_FETCH_LO: nxt = S_LOAD;
                S_LOAD: nxt = S_RUN;
                default: nxt = S_STAB;
            endcase
        end
    end

    // Reset behaves as a power-on
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= S_STAB;
        end else begin
            state_q <= nxt;
        end
    end

    // Down counter loaded on each state entry
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= CNT_W'(STAB_CYC - 1);
        end else if (nxt != state_q || i_power_on) begin
            case (nxt)
                S_STAB: cnt_q <= CNT_W'(STAB_CYC - 1);
                S_PIN_LOW: cnt_q <= CNT_W'(PIN_LOW_CYC - 1);
                S_HOLD: cnt_q <= CNT_W'(HOLD_CYC - 1);
                default: cnt_q <= '0;
            endcase
        end else if (!done) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Pin low time measured only while running; own drive never counts
    always_ff @(posedge i_clk) begin
        if (i_rst || !run || pin_s) begin
            lowc_q <= '0;
        end else if (lowc_q != LOWC_LAST) begin
            lowc_q <= lowc_q + 1'b1;
        end
    end

    always_comb begin
        set_v = '0;
        set_v.ext_pin_flag = ext_evt || hold_low;
        set_v.wdog_flag = run && wd_ovf;
        set_v.bad_opcode_flag = run && op_bad;
        set_v.bad_fetch_flag = run && fetch_bad;
        set_v.monitor_entry_flag = run && i_monitor_entry;
        set_v.low_supply_flag = sup_s && (state_q != S_SUPPLY_LOW);
    end

    // A new cause arriving with the read still lands
    always_ff @(posedge i_clk) begin
        if (i_rst || i_power_on) begin
            o_cause <= CAUSE_RST_VAL;
        end else begin
            o_cause <= (i_cause_rd ? cause_s'('0) : o_cause) | set_v;
        end
    end

    // Open-drain: only a low level is ever driven
    assign o_rst_pin_o = 1'b0;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rst_pin_oe <= 1'b1;
            o_cpu_rst <= 1'b1;
            o_clk_en <= 1'b0;
        end else begin
            o_rst_pin_oe <= (nxt == S_STAB) || (nxt == S_SUPPLY_LOW) || (nxt == S_PIN_LOW);
            o_cpu_rst <= (nxt != S_RUN);
            o_clk_en <= (nxt != S_STAB) && (nxt != S_SUPPLY_LOW);
        end
    end

    // Memory answers one cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_vec_addr <= VEC_HI_ADDR;
            o_vec_rd <= 1'b0;
        end else begin
            o_vec_addr <= (nxt == S_FETCH_LO) ? VEC_LO_ADDR : VEC_HI_ADDR;
            o_vec_rd <= (nxt == S_FETCH_HI) || (nxt == S_FETCH_LO);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pc <= '0;
            o_cpu_start <= 1'b0;
        end else begin
            o_cpu_start <= (state_q == S_LOAD) && (nxt == S_RUN);
            if (state_q == S_FETCH_LO) begin
                o_pc[15:8] <= i_vec_data;
            end
            if (state_q == S_LOAD) begin
                o_pc[7:0] <= i_vec_data;
            end
        end
    end

    // Source select is forced back to divide-by-four for the whole reset
    always_ff @(posedge i_clk) begin
        if (i_rst || nxt != S_RUN) begin
            o_busclk_sel <= BUSCLK_DIV4;
        end else if (i_busclk_wr) begin
            o_busclk_sel <= i_busclk_sel;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Bus clock stalls while clocks are gated for stabilization
    assign o_bus_ce = o_clk_en && ((o_busclk_sel == BUSCLK_DIV4) ? (div_q == BUS_DIV_LAST) : i_pll_ce);

    // Cycles spent in the current state, read by the checks only
    always_ff @(posedge i_clk) begin
        if (i_rst || nxt != state_q || i_power_on) begin
            len_q <= '0;
        end else begin
            len_q <= len_q + 1'b1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_pin_low_len: assert property ((state_q == S_PIN_LOW) && (nxt == S_HOLD) |-> len_q == 13'h001F)
        else $error("reset pin drive not 32 cycles");
    chk_hold_len: assert property ((state_q == S_HOLD) && (nxt == S_FETCH_HI) |-> len_q == 13'h001F)
        else $error("post-release hold not 32 cycles");
    chk_stab_len: assert property ((state_q == S_STAB) && (nxt == S_PIN_LOW) |-> len_q == 13'h0FFF)
        else $error("stabilization delay not 4096 cycles");
    chk_stab_gate: assert property ((state_q == S_STAB) |-> o_rst_pin_oe && !o_clk_en && !o_bus_ce)
        else $error("clocks or pin wrong during stabilization");
    chk_release_fetch: assert property ((state_q == S_STAB) && (nxt == S_PIN_LOW) && !i_power_on && !sup_s
        ##1 (!i_power_on && !sup_s) [*8] |-> o_rst_pin_oe)
        else $error("pin released too early after stabilization");
    chk_fetch_at_64: assert property ((state_q == S_FETCH_HI)
        |-> $past(state_q, 64) != S_STAB && ($past(state_q, 65) != S_STAB || $past(state_q, 64) == S_PIN_LOW))
        else $error("vector fetch not 64 cycles after stabilization");
    chk_vec_order: assert property ((state_q == S_FETCH_HI) |-> o_vec_rd && o_vec_addr == VEC_HI_ADDR
        ##1 o_vec_rd && o_vec_addr == VEC_LO_ADDR)
        else $error("vector bytes fetched out of order");
    chk_por_flags: assert property (i_power_on |=> o_cause == CAUSE_RST_VAL && o_cpu_rst)
        else $error("power-on flags wrong");
    chk_wdog_flag: assert property (run && wd_ovf && !i_power_on |=> o_cause.wdog_flag && o_cpu_rst)
        else $error("watchdog overflow not recorded");
    chk_stop_reset: assert property (run && i_cpu.fetch && i_opcode_stop && !i_stop_allow && !i_power_on
        |=> o_cause.bad_opcode_flag && o_cpu_rst)
        else $error("disallowed stop did not reset");
    chk_data_no_rst: assert property (run && !i_cpu.fetch && !wd_ovf && !i_monitor_entry && !ext_evt
        && !i_power_on && !sup_s |=> !o_cpu_rst)
        else $error("reset without a cause");
    chk_read_clear: assert property (i_cause_rd && set_v == '0 && !i_power_on |=> o_cause == '0)
        else $error("cause flags not cleared by read");
    chk_busclk_div4: assert property (!run |-> o_busclk_sel == BUSCLK_DIV4)
        else $error("bus clock not divide-by-four in reset");
    chk_pin_only_low: assert property (o_rst_pin_o == 1'b0)
        else $error("reset pin driven high");
    chk_supply_pin: assert property ((state_q == S_SUPPLY_LOW) |-> o_rst_pin_oe && !o_clk_en)
        else $error("pin or clocks wrong during low supply");
    chk_supply_flag: assert property (run && sup_s && !i_power_on |=> o_cause.low_supply_flag && o_cpu_rst)
        else $error("low supply not recorded");
    chk_opcode_flag: assert property (run && op_bad && !i_power_on |=> o_cause.bad_opcode_flag && o_cpu_rst)
        else $error("illegal opcode not recorded");
    chk_fetch_flag: assert property (run && fetch_bad && !i_power_on |=> o_cause.bad_fetch_flag && o_cpu_rst)
        else $error("unmapped fetch not recorded");
    chk_ext_flag: assert property (ext_evt && !i_power_on |=> o_cause.ext_pin_flag && o_cpu_rst)
        else $error("external reset not recorded");
    chk_wdog_clear: assert property (run && i_cpu.wr && i_cpu.addr == WDOG_CLR_ADDR |=> !wd_ovf)
        else $error("watchdog overflow right after a clear");
    chk_pin_sample: assert property (hold_low && !i_power_on && !sup_s
        |=> o_cause.ext_pin_flag && state_q == S_EXT_LOW)
        else $error("pin low after hold not recorded");

    cov_por_to_run: cover property ((state_q == S_LOAD) ##1 o_cpu_start);
    cov_wdog_reset: cover property (run && wd_ovf);
    cov_ext_reset: cover property (ext_evt ##[1:200] (state_q == S_FETCH_HI));
    cov_supply_low: cover property ((state_q == S_SUPPLY_LOW) ##1 (state_q == S_STAB));

endmodule : mcu_reset_sequencer

//--- sim/ext_board_model.sv
// Far-side model: pulled-up reset pin with external pull, and vector memory
`timescale 1ns/1ps
module ext_board_model import rst_seq_pkg::*; #(
    parameter logic [15:0] VEC_VAL = 16'hC35A
) (
    input wire logic i_clk,
    input wire logic i_pin_oe,
    input wire logic i_pin_o,
    input wire logic i_ext_low,
    input wire logic [15:0] i_vec_addr,
    input wire logic i_vec_rd,
    output logic o_pin,
    output logic [7:0] o_vec_data
);
    // Pull-up holds the line high unless the device or the outside pulls it low
    assign o_pin = ((i_pin_oe && !i_pin_o) || i_ext_low) ? 1'b0 : 1'b1;

    initial o_vec_data = 8'h5A;

    // One cycle read latency; between reads the data toggles so a late capture shows up
    always @(posedge i_clk) begin
        if (i_vec_rd) begin
            o_vec_data <= (i_vec_addr == VEC_HI_ADDR) ? VEC_VAL[15:8] : VEC_VAL[7:0];
        end else begin
            o_vec_data <= ~o_vec_data;
        end
    end
endmodule : ext_board_model

//--- sim/tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: %s", $time, m); end end
module tb_top import rst_seq_pkg::*;;
    localparam logic [15:0] VEC = 16'hC35A;
    typedef struct {logic [15:0] pc; logic [7:0] cause; int oe; int rl; bit chk;} exp_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] ev = 5'h00;
    logic sup = 1'b0;
    logic ext_low = 1'b0;
    logic stop_allow = 1'b1;
    logic bsel = 1'b0;
    logic pll_ce = 1'b0;
    logic unm = 1'b0;
    logic bad = 1'b0;
    logic stp = 1'b0;
    logic feed = 1'b1;
    cpu_access_s cpu = '0;
    cpu_access_s op_a;
    logic op_unm, op_bad, op_stp;
    bit op_v = 0;
    logic pin, pin_oe, pin_o, vec_rd, cpu_start, cpu_rst, clk_en, busclk_sel, bus_ce;
    logic [7:0] vec_data;
    logic [15:0] vec_addr, pc;
    cause_s cause;
    int seed = 32'h80c8;
    int n_fail = 0;
    int checked = 0;
    int starts = 0;
    int oe_run = 0;
    int oe_len = 0;
    int rst_run = 0;
    exp_s exp_q[$];
    exp_s e;

    mcu_reset_sequencer #(.WDOG_LIMIT(64)) dut (
        .i_clk(clk), .i_rst(rst), .i_power_on(ev[0]), .i_supply_low(sup), .i_rst_pin(pin),
        .o_rst_pin_o(pin_o), .o_rst_pin_oe(pin_oe), .i_cpu(cpu), .i_unmapped(unm), .i_opcode_bad(bad),
        .i_opcode_stop(stp), .i_stop_allow(stop_allow), .i_monitor_entry(ev[1]), .i_vec_data(vec_data),
        .o_vec_addr(vec_addr), .o_vec_rd(vec_rd), .o_pc(pc), .o_cpu_start(cpu_start), .o_cpu_rst(cpu_rst),
        .o_clk_en(clk_en), .i_pll_ce(pll_ce), .i_busclk_wr(ev[3]), .i_busclk_sel(bsel),
        .o_busclk_sel(busclk_sel), .o_bus_ce(bus_ce), .i_cause_rd(ev[2]), .o_cause(cause)
    );

    ext_board_model #(.VEC_VAL(VEC)) partner (
        .i_clk(clk), .i_pin_oe(pin_oe), .i_pin_o(pin_o), .i_ext_low(ext_low),
        .i_vec_addr(vec_addr), .i_vec_rd(vec_rd), .o_pin(pin), .o_vec_data(vec_data)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    // Idle cycles write random data to the watchdog location to keep it fed, except while feed is cleared
    always @(posedge clk) begin
        pll_ce <= 1'($random(seed));
        if (op_v) begin
            cpu <= op_a;
            unm <= op_unm;
            bad <= op_bad;
            stp <= op_stp;
            op_v = 0;
        end else begin
            cpu <= '{addr: WDOG_CLR_ADDR, wdata: 8'($random(seed)), wr: feed, rd: 1'b0, fetch: 1'b0};
            unm <= 1'b0;
            bad <= 1'b0;
            stp <= 1'b0;
        end
    end

    // Result watcher: run lengths of pin drive and CPU reset, checked at each start whose expectation sets chk
    always @(posedge clk) begin
        if (pin_oe === 1'b1) begin
            oe_run++;
        end else if (oe_run != 0) begin
            oe_len = oe_run;
            oe_run = 0;
        end
        if (cpu_start === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(1'b1, 1'b0, "unexpected cpu start")
            end else begin
                e = exp_q.pop_front();
                `CHK(pc, e.pc, "vector value")
                `CHK(cause, e.cause, "reset cause")
                `CHK(busclk_sel, BUSCLK_DIV4, "bus clock source after reset")
                if (e.chk) begin
                    `CHK(oe_len, e.oe, "pin drive length")
                    `CHK(rst_run, e.rl, "cpu reset length")
                end
            end
            starts++;
            oe_len = 0;
            rst_run = 0;
        end else if (cpu_rst === 1'b1) begin
            rst_run++;
        end
    end

    task automatic push(input logic [7:0] c, input int oe, input int rl, input bit chk);
        exp_q.push_back('{pc: VEC, cause: c, oe: oe, rl: rl, chk: chk});
    endtask : push

    task automatic pulse(input int idx);
        @(posedge clk);
        ev[idx] <= 1'b1;
        @(posedge clk);
        ev[idx] <= 1'b0;
    endtask : pulse

    task automatic op(input logic [15:0] a, input logic r, input logic f, input logic u, input logic b,
                      input logic s);
        @(negedge clk);
        op_a = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: r, fetch: f};
        op_unm = u;
        op_bad = b;
        op_stp = s;
        op_v = 1;
        @(posedge clk);
    endtask : op

    task automatic wait_start(input int lim);
        int s0;
        int k;
        s0 = starts;
        k = 0;
        while (starts == s0 && k < lim) begin
            @(posedge clk);
            k++;
        end
        if (starts == s0) begin
            n_fail++;
            $display("Error at %0t: no cpu start", $time);
        end
        repeat (4) @(posedge clk);
    endtask : wait_start

    task automatic give_verdict();
        $display("Counts: checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        int cnt;
        push(8'h82, 0, 0, 0);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wait_start(5000);
        // Power-on in mid-run: full stabilization then pin release then fetch
        pulse(2);
        push(8'h82, 4128, 4163, 1);
        pulse(0);
        wait_start(5000);
        // Read clears every flag
        pulse(2);
        @(negedge clk);
        `CHK(cause, 8'h00, "cause after read")
        // Divide-by-four bus clock gives one enable in four cycles
        cnt = 0;
        repeat (40) begin
            @(posedge clk);
            cnt += (bus_ce === 1'b1) ? 1 : 0;
        end
        `CHK(cnt, 10, "bus clock enables")
        bsel <= 1'b1;
        pulse(3);
        @(negedge clk);
        `CHK(busclk_sel, 1'b1, "bus clock source write")
        // Internal sources: each drives the pin 32 cycles and holds 32 more
        for (int i = 0; i < 5; i++) begin
            pulse(2);
            case (i)
                0: begin push(8'h10, 32, 67, 1); op(16'h1234, 0, 1, 0, 1, 0); end
                1: begin stop_allow <= 1'b0; push(8'h10, 32, 67, 1); op(16'h2000, 0, 1, 0, 0, 1); end
                2: begin push(8'h08, 32, 67, 1); op(16'($random(seed)), 0, 1, 1, 0, 0); end
                3: begin push(8'h04, 32, 67, 1); pulse(1); end
                default: begin push(8'h20, 32, 67, 1); feed <= 1'b0; end
            endcase
            wait_start(400);
            feed <= 1'b1;
            stop_allow <= 1'b1;
        end
        // Data read from unmapped space, allowed stop and a good fetch cause nothing
        op(16'($random(seed)), 1, 0, 1, 0, 0);
        op(16'h2100, 0, 1, 0, 0, 1);
        op(16'h2102, 0, 1, 0, 0, 0);
        repeat (200) @(posedge clk);
        `CHK(cpu_rst, 1'b0, "no reset expected")
        // Pin pulse too short is filtered, a long one resets
        ext_low <= 1'b1;
        repeat (2) @(posedge clk);
        ext_low <= 1'b0;
        repeat (100) @(posedge clk);
        pulse(2);
        push(8'h40, 0, 0, 0);
        ext_low <= 1'b1;
        repeat (6) @(posedge clk);
        ext_low <= 1'b0;
        wait_start(400);
        // Pin still held low when sampled after an internal reset
        pulse(2);
        push(8'h50, 0, 0, 0);
        op(16'h3000, 0, 1, 0, 1, 0);
        repeat (10) @(posedge clk);
        ext_low <= 1'b1;
        repeat (100) @(posedge clk);
        ext_low <= 1'b0;
        wait_start(400);
        // Low supply: pin held while low, then full stabilization
        pulse(2);
        push(8'h02, 0, 0, 0);
        sup <= 1'b1;
        repeat (20) @(posedge clk);
        `CHK(pin, 1'b0, "pin low during low supply")
        sup <= 1'b0;
        wait_start(5000);
        `CHK(exp_q.size(), 0, "all starts seen")
        give_verdict();
    end
endmodule : tb_top
